// File: include/keypad_consts.svh
`ifndef KEYPAD_CONSTS_SVH
`define KEYPAD_CONSTS_SVH

`define KP_ROWS            4
`define KP_COLS            4
`define KP_KEYS            16
`define KP_RATE_W          2
`define KP_DEB_W           3
`define KP_RATE_BASE_NS    10000
`define KP_DEB_BASE_NS     1000000
`define KP_CLK_NS          40
`define KP_SETTLE_CYC      8'h04
`define KP_ROW_IDLE        4'h0
`define KP_ROW_OFF         4'hf
`define KP_KEYS_NONE       16'h0000

`endif

// File: include/keypad_pkg.sv
package keypad_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEBOUNCE,
        ST_SCAN,
        ST_CHECK,
        ST_REPORT,
        ST_RELEASE
    } scan_state_e;

    typedef logic [3:0]  line_t;
    typedef logic [15:0] keys_t;
endpackage

// File: include/tick_if.sv
`timescale 1ns/1ps
interface tick_if;
    logic        start;
    logic [23:0] load;
    logic        done;

    modport ctl (output start, output load, input done);
    modport tmr (input start, input load, output done);
endinterface

// File: verilog/keypad_timer.sv
`timescale 1ns/1ps
module keypad_timer (
    input  wire logic sys_clk,
    input  wire logic resetn,
    tick_if.tmr       tick
);
    logic [23:0] cnt_q;
    logic [23:0] cnt_d;
    logic        run_q;
    logic        run_d;
    logic        done_q;
    logic        done_d;

    always_comb begin
        cnt_d  = cnt_q;
        run_d  = run_q;
        done_d = 1'b0;
        if (tick.start) begin
            cnt_d = tick.load;
            run_d = 1'b1;
        end else if (run_q) begin
            if (cnt_q <= 24'h000001) begin
                run_d  = 1'b0;
                done_d = 1'b1;
            end else begin
                cnt_d = cnt_q - 24'h000001;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q  <= 24'h000000;
            run_q  <= 1'b0;
            done_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            run_q  <= run_d;
            done_q <= done_d;
        end
    end

    assign tick.done = done_q;
endmodule

// File: verilog/keypad_scanner.sv
// Notes on behaviour
// - Scans a passive matrix of up to four rows by four columns.
// - Scan rate and debounce time come from host settings.
// - Masked keys are never reported, but still start debounce and scan unless every key in their column is masked.
// - A closure starts debounce and scan on its own, no command needed.
// - After scan and debounce the active-low interrupt goes low if an unmasked key was closed; otherwise the scanner returns to idle.
// - Every unmasked key closed at scan time is recorded in the result.
`timescale 1ns/1ps
`include "keypad_consts.svh"
module keypad_scanner #(
    parameter int ROWS = `KP_ROWS,
    parameter int COLS = `KP_COLS
) (
    input  wire logic                    sys_clk,
    input  wire logic                    resetn,
    input  wire keypad_pkg::line_t       col_n,
    output      keypad_pkg::line_t       row_drive_n,
    input  wire logic [`KP_RATE_W-1:0]   scan_rate,
    input  wire logic [`KP_DEB_W-1:0]    debounce_sel,
    input  wire keypad_pkg::keys_t       key_mask,
    input  wire logic                    result_read,
    output      keypad_pkg::keys_t       key_result,
    output      logic                    keypad_irq_n,
    output      logic                    scan_busy
);
    import keypad_pkg::*;

    localparam int RATE_CYC = `KP_RATE_BASE_NS / `KP_CLK_NS;
    localparam int DEB_CYC  = `KP_DEB_BASE_NS / `KP_CLK_NS;

    tick_if tick ();

    keypad_timer u_timer (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .tick    (tick)
    );

    scan_state_e state_q;
    scan_state_e state_d;
    line_t       row_q;
    line_t       row_d;
    logic [1:0]  idx_q;
    logic [1:0]  idx_d;
    keys_t       snap_q;
    keys_t       snap_d;
    keys_t       res_q;
    keys_t       res_d;
    logic        irq_n_q;
    logic        irq_n_d;
    logic        busy_q;
    logic        busy_d;
    logic        any_key;
    keys_t       cols_now;
    logic [23:0] rate_load;
    logic [23:0] deb_load;

    always_comb begin
        cols_now = `KP_KEYS_NONE;
        any_key  = 1'b0;
        for (int r = 0; r < ROWS; r++) begin
            for (int c = 0; c < COLS; c++) begin
                if (!col_n[c] && !key_mask[r*4+c]) begin
                    any_key = 1'b1;
                end
            end
        end
        for (int c = 0; c < COLS; c++) begin
            cols_now[c] = ~col_n[c];
        end
    end

    always_comb begin
        rate_load = 24'(RATE_CYC * (32'(scan_rate) + 32'd1));
        deb_load  = 24'(DEB_CYC * (32'(debounce_sel) + 32'd1));
    end

    always_comb begin
        state_d    = state_q;
        row_d      = row_q;
        idx_d      = idx_q;
        snap_d     = snap_q;
        res_d      = res_q;
        irq_n_d    = irq_n_q;
        busy_d     = busy_q;
        tick.start = 1'b0;
        tick.load  = deb_load;
        if (result_read) begin
            irq_n_d = 1'b1;
        end
        case (state_q)
            ST_IDLE: begin
                row_d  = `KP_ROW_IDLE;
                busy_d = 1'b0;
                if (any_key && irq_n_q) begin
                    state_d    = ST_DEBOUNCE;
                    busy_d     = 1'b1;
                    tick.start = 1'b1;
                end
            end
            ST_DEBOUNCE: begin
                if (!any_key) begin
                    state_d = ST_IDLE;
                end else if (tick.done) begin
                    state_d    = ST_SCAN;
                    idx_d      = 2'd0;
                    snap_d     = `KP_KEYS_NONE;
                    row_d      = ~(line_t'(1));
                    tick.start = 1'b1;
                    tick.load  = rate_load;
                end
            end
            ST_SCAN: begin
                if (tick.done) begin
                    for (int c = 0; c < COLS; c++) begin
                        snap_d[{idx_q, 2'(c)}] = cols_now[c];
                    end
                    if (32'(idx_q) == ROWS - 1) begin
                        state_d = ST_CHECK;
                        row_d   = `KP_ROW_IDLE;
                    end else begin
                        idx_d      = idx_q + 2'd1;
                        row_d      = ~(line_t'(1) << (idx_q + 2'd1));
                        tick.start = 1'b1;
                        tick.load  = rate_load;
                    end
                end
            end
            ST_CHECK: begin
                if ((snap_q & ~key_mask) == `KP_KEYS_NONE) begin
                    state_d = ST_IDLE;
                end else begin
                    state_d = ST_REPORT;
                end
            end
            ST_REPORT: begin
                res_d   = snap_q & ~key_mask;
                irq_n_d = 1'b0;
                state_d = ST_RELEASE;
            end
            ST_RELEASE: begin
                if (!any_key && irq_n_q) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
            row_q   <= `KP_ROW_OFF;
            idx_q   <= 2'd0;
            snap_q  <= `KP_KEYS_NONE;
            res_q   <= `KP_KEYS_NONE;
            irq_n_q <= 1'b1;
            busy_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            row_q   <= row_d;
            idx_q   <= idx_d;
            snap_q  <= snap_d;
            res_q   <= res_d;
            irq_n_q <= irq_n_d;
            busy_q  <= busy_d;
        end
    end

    assign row_drive_n  = row_q;
    assign key_result   = res_q;
    assign keypad_irq_n = irq_n_q;
    assign scan_busy    = busy_q;
endmodule

// File: dv/keypad_monitor.sv
`timescale 1ns/1ps
module keypad_monitor (
    input wire logic              sys_clk,
    input wire logic              resetn,
    input wire keypad_pkg::line_t col_n,
    input wire keypad_pkg::line_t row_drive_n,
    input wire keypad_pkg::keys_t key_mask,
    input wire logic              result_read,
    input wire keypad_pkg::keys_t key_result,
    input wire logic              keypad_irq_n,
    input wire logic              scan_busy
);
    import keypad_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    row_order_a: assert property (
        $onehot0(~row_drive_n) || row_drive_n == 4'h0) else $error("rows");
    deb_rows_a: assert property (
        $rose(scan_busy) |-> (row_drive_n == 4'h0)[*8]) else $error("deb");
    mask_res_a: assert property (
        $fell(keypad_irq_n) |-> (key_result & key_mask) == 16'h0000)
        else $error("masked key");
    auto_start_a: assert property (
        $rose(scan_busy) |-> $past(col_n) != 4'hf) else $error("start");
    irq_after_a: assert property (
        $fell(keypad_irq_n) |-> $past(scan_busy)) else $error("early irq");
    result_keys_a: assert property (
        $fell(keypad_irq_n) |-> key_result != 16'h0000) else $error("empty");
    irq_hold_a: assert property (
        !keypad_irq_n && !result_read |=> !keypad_irq_n && $stable(key_result))
        else $error("irq dropped");
    irq_release_a: assert property (
        !keypad_irq_n && result_read |=> keypad_irq_n) else $error("irq kept");
endmodule
bind keypad_scanner keypad_monitor keypad_monitor_inst (.sys_clk, .resetn,
    .col_n, .row_drive_n, .key_mask, .result_read, .key_result,
    .keypad_irq_n, .scan_busy);

// File: dv/keypad_matrix.sv
`timescale 1ns/1ps
module keypad_matrix (
    input wire keypad_pkg::line_t row_drive_n,
    input wire keypad_pkg::keys_t keys,
    output     keypad_pkg::line_t col_n
);
    import keypad_pkg::*;
    always_comb begin
        col_n = 4'hf;
        for (int r = 0; r < 4; r++) begin
            for (int c = 0; c < 4; c++) begin
                if (!row_drive_n[r] && keys[r*4+c]) begin
                    col_n[c] = 1'b0;
                end
            end
        end
    end
endmodule

// File: dv/matrix_keypad_scanner_tb.sv
`timescale 1ns/1ps
module matrix_keypad_scanner_tb;
    import keypad_pkg::*;
    logic       sys_clk = 1'b0;
    logic       resetn = 1'b0;
    line_t      col_n;
    line_t      row_drive_n;
    logic [1:0] scan_rate = 2'h0;
    logic [2:0] debounce_sel = 3'h0;
    keys_t      key_mask = 16'h0000;
    keys_t      keys = 16'h0000;
    keys_t      key_result;
    logic       result_read = 1'b0;
    logic       keypad_irq_n;
    logic       scan_busy;
    logic       prev_irq_n = 1'b1;
    keys_t      exp_q[$];
    int         bad_count = 0;
    int         checks = 0;
    always #20 sys_clk = ~sys_clk;
    keypad_scanner keypad_scanner_inst (.sys_clk, .resetn, .col_n,
        .row_drive_n, .scan_rate, .debounce_sel, .key_mask, .result_read,
        .key_result, .keypad_irq_n, .scan_busy);
    keypad_matrix keypad_matrix_inst (.row_drive_n, .keys, .col_n);
    task automatic check(string nm, keys_t exp, keys_t seen);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wait_while(ref logic s);
        int n = 0;
        while (s !== 1'b0 && n < 60000) begin
            @(posedge sys_clk);
            n++;
        end
    endtask
    // Press, wait for report, read, release
    task automatic press(keys_t k, keys_t m);
        @(posedge sys_clk);
        key_mask <= m;
        keys <= k;
        exp_q.push_back(k & ~m);
        wait_while(keypad_irq_n);
        repeat (5) @(posedge sys_clk);
        check("irq held", 16'h0000, {15'h0, keypad_irq_n});
        result_read <= 1'b1;
        @(posedge sys_clk);
        result_read <= 1'b0;
        keys <= 16'h0000;
        @(negedge sys_clk);
        check("irq free", 16'h0001, {15'h0, keypad_irq_n});
        wait_while(scan_busy);
    endtask
    // Result checked on each falling interrupt
    always @(negedge sys_clk) begin
        if (resetn && prev_irq_n && keypad_irq_n === 1'b0) begin
            if (exp_q.size() == 0) begin
                check("stray irq", 16'h0001, 16'h0000);
            end else begin
                check("key result", exp_q.pop_front(), key_result);
            end
        end
        prev_irq_n = keypad_irq_n;
    end
    initial begin
        keys_t m;
        void'($urandom(18));
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        // Four rows at once, one key masked
        press(16'h8421, 16'h0020);
        // Only masked keys closed: no scan
        // Whole column masked, idle rows cannot tell keys apart
        m = 16'($urandom) | 16'h2222;
        m[0] = 1'b0;
        key_mask <= m;
        keys <= 16'h2222;
        repeat (50) @(posedge sys_clk);
        check("busy masked", 16'h0000, {15'h0, scan_busy});
        keys <= 16'h0000;
        repeat (4) @(posedge sys_clk);
        scan_rate <= 2'($urandom);
        debounce_sel <= 3'h1;
        press(16'($urandom) | 16'h0001, m);
        check("all reported", 16'h0000, 16'(exp_q.size()));
        final_report();
    end
    always begin
        #(40.0 * 95000);
        bad_count++;
        final_report();
    end
endmodule
